/* logic/segment_lcd_driver_control.sv */
// Segment panel driver control: registers, clock gate, sequencer
// Contract
// - Output enable 1 drives common and segment lines; 0 leaves them high impedance.
// - At 1/6 duty with packing set, one display RAM byte holds one segment.
// - At 1/6 duty with packing clear, each segment uses a six-bit RAM group.
// - Duty field: 00 is 1/4, 01 is 1/6, 10 and 11 are 1/8.
// - Ladder field bits 3:2 pick 300k, 600k, 150k or 200k per resistor.
// - Frame field picks 512, 256, 128 or 64 Hz, reset 64 Hz.
// - Setting the clock gate bit stops the panel clock; reset leaves it running.
// - Gate request takes effect only while the PLL feeds both system clocks.
// - At 1/8 duty the bias bit picks 1/3 or 1/4 bias.
// - At 1/4 or 1/6 duty bias is 1/3 whatever the bias bit.
// - Amplifier trim bits 2:1 give 0%, -33%, 100% or +33% bias.
// - Bit 0 of the battery register enables battery discharge, reset off.
// - Offset disable bit removes the 10 mV input offset; software keeps it zero.
// - Waveform voltage bit gives 3.3 V at 0 and 3.0 V at 1.
// - Power detect disable bit turns the detector off; set only on 3.3 V parts.
// - Regulator boost bit doubles the regulator bias current.
// - Analog regulator field selects 3.0 to 3.5 V per its code table.
// - Digital supply trim field selects offsets from -0.5 V to +0.2 V.
`timescale 1ns/100ps
`include "lcd_ctrl_defs.svh"
module segment_lcd_driver_control
  import lcd_ctrl_pkg::*;
#(
  parameter int FRAME_BASE_CYC = `CLK_HZ / `FRAME_HZ_MAX,
  parameter int LIM_W = 18
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Clock source status
  input wire logic pll_feeds_both_i,
  // Panel drive
  output logic [7:0] com_sel_o,
  output logic [7:0] com_oe_o,
  output logic seg_oe_o,
  output logic frame_phase_o,
  output logic [3:0] seg_stride_o,
  output logic byte_per_seg_o,
  output logic panel_clock_run_o,
  // Bias network and frame rate
  output logic bias_quarter_o,
  output logic [9:0] ladder_kohm_o,
  output logic [9:0] frame_hz_o,
  // Analog trims
  output logic [7:0] amp_bias_pct_o,
  output logic battery_discharge_enable_o,
  output logic input_offset_disable_o,
  output logic [11:0] waveform_mv_o,
  output logic power_detect_disable_o,
  output logic regulator_bias_boost_o,
  output logic [11:0] analog_regulator_mv_o,
  output logic [9:0] digital_supply_trim_mv_o
);

  ctrl_state_s s;
  ctrl_state_s next_s;
  logic req;
  logic wr;
  logic com_step;
  logic [2:0] last_com;
  logic [LIM_W-1:0] frame_limit;

  // Ladder resistance per code
  function automatic logic [9:0] ladder_dec(input logic [1:0] c);
    case (c)
      2'h0: ladder_dec = 10'h12c; // 300k
      2'h1: ladder_dec = 10'h258; // 600k
      2'h2: ladder_dec = 10'h096; // 150k
      default: ladder_dec = 10'h0c8; // 200k
    endcase
  endfunction : ladder_dec

  // Frame rate per code
  function automatic logic [9:0] frame_dec(input logic [1:0] c);
    case (c)
      2'h3: frame_dec = 10'h200; // 512 Hz
      2'h2: frame_dec = 10'h100; // 256 Hz
      2'h1: frame_dec = 10'h080; // 128 Hz
      default: frame_dec = 10'h040; // 64 Hz
    endcase
  endfunction : frame_dec

  // Amplifier bias adjust in percent, signed
  function automatic logic [7:0] amp_dec(input logic [1:0] c);
    case (c)
      2'h0: amp_dec = 8'h00; // 0%
      2'h1: amp_dec = 8'hdf; // -33%
      2'h3: amp_dec = 8'h21; // +33%
      default: amp_dec = 8'h64; // 100%
    endcase
  endfunction : amp_dec

  // Analog regulator output in mV
  function automatic logic [11:0] areg_dec(input logic [2:0] c);
    case (c)
      3'h0: areg_dec = 12'hce4; // 3.3 V
      3'h1: areg_dec = 12'hc80; // 3.2 V
      3'h3: areg_dec = 12'hd48; // 3.4 V
      3'h6: areg_dec = 12'hc1c; // 3.1 V
      3'h7: areg_dec = 12'hbb8; // 3.0 V
      default: areg_dec = 12'hdac; // 3.5 V
    endcase
  endfunction : areg_dec

  // Digital supply offset in mV, signed
  function automatic logic [9:0] dtrim_dec(input logic [2:0] c);
    case (c)
      3'h0: dtrim_dec = 10'h000; // +0
      3'h1: dtrim_dec = 10'h39c; // -0.1 V
      3'h2: dtrim_dec = 10'h0c8; // +0.2 V
      3'h3: dtrim_dec = 10'h064; // +0.1 V
      3'h4: dtrim_dec = 10'h270; // -0.4 V
      3'h5: dtrim_dec = 10'h20c; // -0.5 V
      3'h6: dtrim_dec = 10'h338; // -0.2 V
      default: dtrim_dec = 10'h2d4; // -0.3 V
    endcase
  endfunction : dtrim_dec

  // Bus request and write qualifier
  assign req = wb_cyc_i && wb_stb_i && !s.ack;
  assign wr = req && wb_we_i && wb_sel_i[0];

  // Last common index and frame period for the pacing timer
  always_comb begin
    case (s.drv[`F_DUTY])
      `DUTY_4: last_com = 3'(`COMS_4 - 4'h1);
      `DUTY_6: last_com = 3'(`COMS_6 - 4'h1);
      default: last_com = 3'(`COMS_8 - 4'h1);
    endcase
    frame_limit = LIM_W'(FRAME_BASE_CYC) << (`FRAME_MAX_CODE - s.drv[`F_FRAME]);
  end

  // Common step pacing, runs only while sequencing
  com_step_timer #(
    .W(LIM_W)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(s.st == ST_RUN),
    .inc_i(s.stride == `COMS_4 ? `COMS_4 : (s.drv[`B_DUTY_HI] ? `COMS_8 : `COMS_6)),
    .limit_i(frame_limit),
    .step_o(com_step)
  );

  // Next state: bus slave, decodes and sequencer
  always_comb begin
    next_s = s;
    next_s.ack = req;
    next_s.rdat = 8'h00;
    // Read mux, unmapped reads zero
    if (req) begin
      case (wb_adr_i[15:2])
        `IDX_SYSCLK: next_s.rdat = 8'(s.gate) << `B_GATE;
        `IDX_BAT: next_s.rdat = s.bat;
        `IDX_LCDV: next_s.rdat = s.lcdv;
        `IDX_LDO: next_s.rdat = s.ldo;
        `IDX_DRV: next_s.rdat = s.drv;
        default: next_s.rdat = 8'h00;
      endcase
    end
    // Register writes through byte lane 0
    if (wr) begin
      case (wb_adr_i[15:2])
        `IDX_SYSCLK: next_s.gate = wb_dat_i[`B_GATE];
        `IDX_BAT: next_s.bat = wb_dat_i[7:0];
        `IDX_LCDV: next_s.lcdv = wb_dat_i[7:0];
        `IDX_LDO: next_s.ldo = wb_dat_i[7:0];
        `IDX_DRV: next_s.drv = wb_dat_i[7:0];
        default: next_s.drv = s.drv;
      endcase
    end
    // Panel clock gate, honoured only on PLL clocks
    next_s.clk_run = !(s.gate && pll_feeds_both_i);
    // Duty and RAM packing
    case (s.drv[`F_DUTY])
      `DUTY_4: begin
        next_s.stride = `COMS_4;
        next_s.pack_byte = 1'b0;
      end
      `DUTY_6: begin
        next_s.stride = s.drv[`B_PACK] ? `COMS_8 : `COMS_6;
        next_s.pack_byte = s.drv[`B_PACK];
      end
      default: begin
        next_s.stride = `COMS_8;
        next_s.pack_byte = 1'b1;
      end
    endcase
    // Bias ratio, 1/4 only at 1/8 duty
    next_s.bias_q = s.drv[`B_DUTY_HI] && s.bat[`B_BIAS];
    next_s.ladder = ladder_dec(s.drv[`F_LADDER]);
    next_s.frame_hz = frame_dec(s.drv[`F_FRAME]);
    // Analog trims
    next_s.amp_pct = amp_dec(s.bat[`F_AMP]);
    next_s.wave_mv = s.lcdv[`B_WAVE] ? 12'hbb8 : 12'hce4;
    next_s.areg_mv = areg_dec(s.ldo[`F_AREG]);
    next_s.dtrim_mv = dtrim_dec(s.ldo[`F_DTRIM]);
    // Waveform sequencer
    case (s.st)
      ST_OFF: begin
        next_s.com_idx = 3'h0;
        next_s.phase = 1'b0;
        if (s.drv[`B_OUT_EN]) begin
          next_s.st = s.clk_run ? ST_RUN : ST_HOLD;
        end
      end
      ST_RUN: begin
        if (!s.drv[`B_OUT_EN]) begin
          next_s.st = ST_OFF;
        end else if (!s.clk_run) begin
          next_s.st = ST_HOLD;
        end else if (com_step) begin
          if (s.com_idx >= last_com) begin
            next_s.com_idx = 3'h0;
            next_s.phase = !s.phase;
          end else begin
            next_s.com_idx = s.com_idx + 3'h1;
          end
        end
      end
      ST_HOLD: begin
        if (!s.drv[`B_OUT_EN]) begin
          next_s.st = ST_OFF;
        end else if (s.clk_run) begin
          next_s.st = ST_RUN;
        end
      end
      default: next_s.st = ST_OFF;
    endcase
    // Pin drive enables follow the output enable bit
    if (s.drv[`B_OUT_EN]) begin
      next_s.seg_oe = 1'b1;
      case (s.drv[`F_DUTY])
        `DUTY_4: next_s.com_oe = `MASK_4;
        `DUTY_6: next_s.com_oe = `MASK_6;
        default: next_s.com_oe = `MASK_8;
      endcase
      next_s.com_sel = (s.com_idx > last_com) ? `COM_FIRST : `COM_FIRST << s.com_idx;
    end else begin
      next_s.seg_oe = 1'b0;
      next_s.com_oe = 8'h00;
      next_s.com_sel = 8'h00;
    end
  end

  // State register with documented reset values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.drv <= `RST_BYTE;
      s.bat <= `RST_BYTE;
      s.lcdv <= `RST_BYTE;
      s.ldo <= `RST_BYTE;
      s.st <= ST_OFF;
      s.clk_run <= 1'b1;
      s.stride <= `COMS_4;
      s.ladder <= 10'h12c;
      s.frame_hz <= 10'h040;
      s.wave_mv <= 12'hce4;
      s.areg_mv <= 12'hce4;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign wb_dat_o = {24'h000000, s.rdat};
  assign wb_ack_o = s.ack;
  assign com_sel_o = s.com_sel;
  assign com_oe_o = s.com_oe;
  assign seg_oe_o = s.seg_oe;
  assign frame_phase_o = s.phase;
  assign seg_stride_o = s.stride;
  assign byte_per_seg_o = s.pack_byte;
  assign panel_clock_run_o = s.clk_run;
  assign bias_quarter_o = s.bias_q;
  assign ladder_kohm_o = s.ladder;
  assign frame_hz_o = s.frame_hz;
  assign amp_bias_pct_o = s.amp_pct;
  assign battery_discharge_enable_o = s.bat[`B_DISCH];
  assign input_offset_disable_o = s.lcdv[`B_OFFS];
  assign waveform_mv_o = s.wave_mv;
  assign power_detect_disable_o = s.ldo[`B_PDET];
  assign regulator_bias_boost_o = s.ldo[`B_BOOST];
  assign analog_regulator_mv_o = s.areg_mv;
  assign digital_supply_trim_mv_o = s.dtrim_mv;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Bus write to the driver control register
  sequence drv_write_s;
    wr && wb_adr_i[15:2] == `IDX_DRV;
  endsequence

  // Bus request not yet answered
  sequence req_s;
    req;
  endsequence

  // One-cycle answer
  ack_timing_a: assert property (req_s |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse one cycle after request");

  // Written byte lands in the driver control register
  drv_write_a: assert property (drv_write_s |=> s.drv == $past(wb_dat_i[7:0]))
    else $error("driver control write lost");

  // Pins float while output enable is clear
  hiz_off_a: assert property (!s.drv[`B_OUT_EN] |=> (com_oe_o == 8'h00) && !seg_oe_o)
    else $error("panel pins driven while disabled");

  // Pins driven while output enable is set
  drive_on_a: assert property (s.drv[`B_OUT_EN] |=> seg_oe_o && com_oe_o[0])
    else $error("panel pins not driven while enabled");

  // Bias 1/4 only at 1/8 duty with bias bit
  bias_ratio_a: assert property (bias_quarter_o |-> $past(s.drv[`B_DUTY_HI] && s.bat[`B_BIAS]))
    else $error("quarter bias outside 1/8 duty");

  // Gate honoured only with PLL clocks
  clock_gate_a: assert property (##1 panel_clock_run_o == !$past(s.gate && pll_feeds_both_i))
    else $error("panel clock gate wrong");

  // Sequencer frozen while panel clock stopped
  seq_hold_a: assert property (s.st == ST_HOLD |=> $stable(s.com_idx) && $stable(s.phase))
    else $error("sequencer moved without panel clock");

  // RAM stride per packing bit at 1/6 duty
  ram_stride_a: assert property (s.drv[`F_DUTY] == `DUTY_6 |=>
    seg_stride_o == ($past(s.drv[`B_PACK]) ? `COMS_8 : `COMS_6))
    else $error("wrong RAM stride at 1/6 duty");

  // Ladder decode
  ladder_code_a: assert property (##1 ladder_kohm_o == ladder_dec($past(s.drv[`F_LADDER])))
    else $error("ladder resistance decode wrong");

  // Frame rate decode
  frame_code_a: assert property (##1 frame_hz_o == frame_dec($past(s.drv[`F_FRAME])))
    else $error("frame rate decode wrong");

  // Regulator output decode
  regulator_code_a: assert property (##1 analog_regulator_mv_o == areg_dec($past(s.ldo[`F_AREG])))
    else $error("regulator voltage decode wrong");

  // Waveform voltage decode
  wave_volt_a: assert property (s.lcdv[`B_WAVE] |=> waveform_mv_o == 12'hbb8)
    else $error("waveform voltage decode wrong");

endmodule : segment_lcd_driver_control

/* logic/lcd_ctrl_defs.svh */
// Register indices, field positions, reset values and codes of the panel driver control
`ifndef LCD_CTRL_DEFS_SVH
`define LCD_CTRL_DEFS_SVH
// Clock rate and fastest frame rate
`define CLK_HZ 10000000
`define FRAME_HZ_MAX 512
// Register indices, byte address is index times four
`define IDX_SYSCLK 14'h0080
`define IDX_BAT 14'h285c
`define IDX_LCDV 14'h285e
`define IDX_LDO 14'h2866
`define IDX_DRV 14'h2c1e
`define RST_BYTE 8'h00
// Display driver control fields
`define B_OUT_EN 7
`define B_PACK 6
`define F_DUTY 5:4
`define B_DUTY_HI 5
`define F_LADDER 3:2
`define F_FRAME 1:0
// System clock switch control
`define B_GATE 3
// Battery discharge and bias control
`define B_BIAS 3
`define F_AMP 2:1
`define B_DISCH 0
// Display voltage control
`define B_OFFS 7
`define B_WAVE 2
// Regulator control
`define B_PDET 7
`define B_BOOST 6
`define F_AREG 5:3
`define F_DTRIM 2:0
// Duty codes and derived figures
`define DUTY_4 2'h0
`define DUTY_6 2'h1
`define COMS_4 4'h4
`define COMS_6 4'h6
`define COMS_8 4'h8
`define MASK_4 8'h0f
`define MASK_6 8'h3f
`define MASK_8 8'hff
`define COM_FIRST 8'h01
`define FRAME_MAX_CODE 2'h3
`endif

/* logic/lcd_ctrl_pkg.sv */
// Types shared by the panel driver control design
package lcd_ctrl_pkg;

  // Waveform sequencer states
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_RUN = 3'b010,
    ST_HOLD = 3'b100
  } seq_state_e;

  // Whole state of the control block
  typedef struct packed {
    logic [7:0] drv;
    logic [7:0] bat;
    logic [7:0] lcdv;
    logic [7:0] ldo;
    logic gate;
    logic ack;
    logic [7:0] rdat;
    seq_state_e st;
    logic [2:0] com_idx;
    logic phase;
    logic [7:0] com_sel;
    logic [7:0] com_oe;
    logic seg_oe;
    logic [3:0] stride;
    logic pack_byte;
    logic bias_q;
    logic [9:0] ladder;
    logic [9:0] frame_hz;
    logic clk_run;
    logic [7:0] amp_pct;
    logic [11:0] wave_mv;
    logic [11:0] areg_mv;
    logic [9:0] dtrim_mv;
  } ctrl_state_s;

endpackage : lcd_ctrl_pkg

/* logic/com_step_timer.sv */
// Fractional divider that paces common line steps within a frame
`timescale 1ns/100ps
module com_step_timer #(
  parameter int W = 18
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pacing control
  input wire logic run_i,
  input wire logic [3:0] inc_i,
  input wire logic [W-1:0] limit_i,
  // Step pulse
  output logic step_o
);

  typedef struct packed {
    logic [W-1:0] acc;
    logic step;
  } timer_s;

  timer_s t;
  timer_s next_t;
  logic [W:0] sum;

  // Add commons per cycle, step each time a frame share is reached
  always_comb begin
    next_t = t;
    next_t.step = 1'b0;
    sum = {1'b0, t.acc} + (W+1)'(inc_i);
    if (run_i) begin
      if (sum >= {1'b0, limit_i}) begin
        next_t.acc = W'(sum - {1'b0, limit_i});
        next_t.step = 1'b1;
      end else begin
        next_t.acc = W'(sum);
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t <= '0;
    end else begin
      t <= next_t;
    end
  end

  assign step_o = t.step;

endmodule : com_step_timer

/* dv/panel_glass_model.sv */
// Passive model of the segment panel: counts frames and flags bad common drive
`timescale 1ns/100ps
module panel_glass_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Drive seen at the glass
  input wire logic [7:0] com_sel_i,
  input wire logic [7:0] com_oe_i,
  input wire logic seg_oe_i,
  input wire logic frame_phase_i,
  // Observations
  output int frames_o,
  output int faults_o
);
  logic phase_q;

  // Count inversion flips and commons driven off the enabled set
  always_ff @(posedge clk_i) begin
    phase_q <= frame_phase_i;
    if (rst_i) begin
      frames_o <= 0;
      faults_o <= 0;
    end else begin
      if (phase_q !== frame_phase_i) frames_o <= frames_o + 1;
      if (seg_oe_i && (!$onehot(com_sel_i) || (com_sel_i & ~com_oe_i) != 8'h00)) faults_o <= faults_o + 1;
    end
  end
endmodule : panel_glass_model

/* dv/segment_lcd_driver_control_tb.sv */
// Self-checking bench for the panel driver control block
`timescale 1ns/100ps
module segment_lcd_driver_control_tb;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, pll_feeds_both_i;
  logic [15:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic wb_ack_o, seg_oe_o, frame_phase_o, byte_per_seg_o, panel_clock_run_o, bias_quarter_o;
  logic [7:0] com_sel_o, com_oe_o, amp_bias_pct_o;
  logic [3:0] seg_stride_o;
  logic [9:0] ladder_kohm_o, frame_hz_o, digital_supply_trim_mv_o;
  logic battery_discharge_enable_o, input_offset_disable_o, power_detect_disable_o, regulator_bias_boost_o;
  logic [11:0] waveform_mv_o, analog_regulator_mv_o;
  int frames, faults, num_errors, samples_checked;
  localparam logic [9:0] LAD [4] = '{10'h12c, 10'h258, 10'h096, 10'h0c8};
  localparam logic [9:0] FHZ [4] = '{10'h040, 10'h080, 10'h100, 10'h200};
  localparam logic [7:0] AMP [4] = '{8'h00, 8'hdf, 8'h64, 8'h21};
  localparam logic [11:0] AREG [8] = '{12'hce4, 12'hc80, 12'hdac, 12'hd48, 12'hdac, 12'hdac, 12'hc1c, 12'hbb8};
  localparam logic [9:0] DTR [8] = '{10'h000, 10'h39c, 10'h0c8, 10'h064, 10'h270, 10'h20c, 10'h338, 10'h2d4};

  segment_lcd_driver_control #(.FRAME_BASE_CYC(16), .LIM_W(18)) u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pll_feeds_both_i, .com_sel_o, .com_oe_o,
    .seg_oe_o, .frame_phase_o, .seg_stride_o, .byte_per_seg_o, .panel_clock_run_o, .bias_quarter_o,
    .ladder_kohm_o, .frame_hz_o, .amp_bias_pct_o, .battery_discharge_enable_o, .input_offset_disable_o,
    .waveform_mv_o, .power_detect_disable_o, .regulator_bias_boost_o, .analog_regulator_mv_o,
    .digital_supply_trim_mv_o);

  panel_glass_model u_panel (.clk_i, .rst_i, .com_sel_i(com_sel_o), .com_oe_i(com_oe_o), .seg_oe_i(seg_oe_o),
    .frame_phase_i(frame_phase_o), .frames_o(frames), .faults_o(faults));

  // Clock, 100 ns period
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("Counts: %0d compared, %0d mismatched", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out

  // One classic cycle, held until ack is sampled high or 20 cycles pass
  task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= 4'h1;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o[7:0];
    check("ack", wb_ack_o, 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
    repeat (3) @(negedge clk_i);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    check("readback", q, exp);
  endtask : rd

  task automatic test_reset();
    rd(16'ha170, 8'h00);
    rd(16'ha178, 8'h00);
    rd(16'ha198, 8'h00);
    rd(16'hb078, 8'h00);
    rd(16'h0200, 8'h00);
    wr(16'h0300, 8'hff);
    rd(16'h0300, 8'h00);
    check("seg_oe", seg_oe_o, 1'b0);
    check("com_oe", com_oe_o, 8'h00);
    check("clock_run", panel_clock_run_o, 1'b1);
    check("stride", seg_stride_o, 4'h4);
    check("ladder_rst", ladder_kohm_o, 10'h12c);
    check("frame_rst", frame_hz_o, 10'h040);
    check("bias_rst", bias_quarter_o, 1'b0);
    check("discharge_rst", battery_discharge_enable_o, 1'b0);
    check("wave_rst", waveform_mv_o, 12'hce4);
    check("pdet_rst", power_detect_disable_o, 1'b0);
    check("areg_rst", analog_regulator_mv_o, 12'hce4);
    $display("test reset done");
  endtask : test_reset

  task automatic test_duty();
    logic [1:0] d;
    wr(16'ha170, 8'h08);
    for (int i = 0; i < 8; i++) begin
      d = i[1:0];
      wr(16'hb078, {1'b1, i[2], d, 4'h3});
      check("com_oe", com_oe_o, d == 2'h0 ? 8'h0f : d == 2'h1 ? 8'h3f : 8'hff);
      check("stride", seg_stride_o, d == 2'h0 ? 4'h4 : (d == 2'h1 && !i[2]) ? 4'h6 : 4'h8);
      check("byte_mode", byte_per_seg_o, d[1] | (d[0] & i[2]));
      check("bias", bias_quarter_o, d[1]);
    end
    wr(16'ha170, 8'h00);
    check("bias", bias_quarter_o, 1'b0);
    $display("test duty done");
  endtask : test_duty

  task automatic test_frames();
    int f0;
    wr(16'hb078, 8'h83);
    check("seg_oe", seg_oe_o, 1'b1);
    f0 = frames;
    repeat (160) @(negedge clk_i);
    check("fast_frames", (frames - f0) inside {[9:11]}, 1'b1);
    wr(16'hb078, 8'h80);
    f0 = frames;
    repeat (512) @(negedge clk_i);
    check("slow_frames", (frames - f0) inside {[3:5]}, 1'b1);
    $display("test frames done");
  endtask : test_frames

  task automatic test_gate();
    logic [7:0] held;
    int f0;
    wr(16'hb078, 8'h83);
    wr(16'h0200, 8'h08);
    rd(16'h0200, 8'h08);
    check("run_no_pll", panel_clock_run_o, 1'b1);
    pll_feeds_both_i <= 1'b1;
    repeat (3) @(negedge clk_i);
    check("run_gated", panel_clock_run_o, 1'b0);
    held = com_sel_o;
    f0 = frames;
    repeat (60) @(negedge clk_i);
    check("com_frozen", com_sel_o, held);
    check("no_frames", frames - f0, 0);
    @(posedge clk_i);
    pll_feeds_both_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    check("run_pll_lost", panel_clock_run_o, 1'b1);
    wr(16'h0200, 8'h00);
    wr(16'hb078, 8'h00);
    check("com_off", com_oe_o | com_sel_o, 8'h00);
    check("seg_off", seg_oe_o, 1'b0);
    check("panel_faults", faults, 0);
    $display("test gate done");
  endtask : test_gate

  task automatic test_trims();
    for (int i = 0; i < 4; i++) begin
      wr(16'hb078, {4'h0, i[1:0], i[1:0]});
      check("ladder", ladder_kohm_o, LAD[i]);
      check("frame_hz", frame_hz_o, FHZ[i]);
      wr(16'ha170, {5'h00, i[1:0], i[0]});
      check("amp", amp_bias_pct_o, AMP[i]);
      check("discharge", battery_discharge_enable_o, i[0]);
    end
    for (int i = 0; i < 8; i++) begin
      wr(16'ha198, {i[0], i[1], i[2:0], i[2:0]});
      check("areg", analog_regulator_mv_o, AREG[i]);
      check("dtrim", digital_supply_trim_mv_o, DTR[i]);
      check("pdet", power_detect_disable_o, i[0]);
      check("boost", regulator_bias_boost_o, i[1]);
    end
    rd(16'ha198, 8'hff);
    wr(16'ha178, 8'h84);
    check("wave", waveform_mv_o, 12'hbb8);
    check("offset", input_offset_disable_o, 1'b1);
    wr(16'ha178, 8'h00);
    check("wave", waveform_mv_o, 12'hce4);
    $display("test trims done");
  endtask : test_trims

  // Main sequence
  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, pll_feeds_both_i} = 4'h0;
    wb_adr_i = 16'h0000;
    wb_sel_i = 4'h1;
    wb_dat_i = 32'h00000000;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    test_reset();
    test_duty();
    test_frames();
    test_gate();
    test_trims();
    close_out();
  end

  // Watchdog
  initial begin
    #2000000;
    num_errors++;
    close_out();
  end
endmodule : segment_lcd_driver_control_tb
